// >>> reset_config_sequencer.sv
/*
  Reset and start-up configuration sequencer. Watches the master reset pin, latches
  start-up pins, and steps a loader engine through info load, defaults, memory probe,
  update scan, OTP and memory configuration, hotfix and completion.
  Assumes the loader engine and PLL run on i_sys_clk and answer one job at a time.
*/
`timescale 1ns/100ps
`include "reset_config_sequencer_regs.svh"

module reset_config_sequencer #(
  parameter int GPIO_W   = 8,
  parameter int SEL_PINS = 4
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire logic              i_master_reset_n,
  input  wire logic              i_test_mode_n,
  input  wire logic [GPIO_W-1:0] i_gpio,
  output logic                   o_task_req,
  output rcs_pkg::task_t         o_task,
  input  wire logic              i_task_done,
  input  wire logic              i_task_ok,
  output logic [6:0]             o_ee_addr,
  output rcs_pkg::ee_speed_t     o_ee_speed,
  output logic [15:0]            o_ee_offset,
  output logic [3:0]             o_cfg_sel,
  input  wire logic              i_cfg_fbdiv,
  input  wire logic              i_cfg_spi_mode,
  input  wire logic              i_cfg_spi_3wire,
  input  wire logic              i_hotfix_present,
  output logic                   o_pll_cal_start,
  input  wire logic              i_pll_lock,
  output logic                   o_spi_mode,
  output logic                   o_spi_4wire,
  output logic                   o_serial_en,
  output logic                   o_clk_out_en,
  output logic                   o_gpio_out_en,
  output logic                   o_mon_en,
  output logic                   o_alarm_en,
  output logic                   o_seq_done,
  output logic [3:0]             o_cfg_num,
  output logic [6:0]             o_status
);

  // -----------------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------------
  typedef struct packed {
    rcs_pkg::seq_state_t state;
    rcs_pkg::task_t      tsk;
    logic                busy;
    logic [1:0]          low_cnt;
    logic                in_reset;
    logic                pin_prev;
    logic                released;
    logic [GPIO_W-1:0]   gpio_lat;
    logic [2:0]          ee_idx;
    rcs_pkg::ee_speed_t  ee_spd;
    logic                ee_off;
    logic                ee_found;
    logic                upd_done;
    logic                cfg_loaded;
    logic                pll_start;
    logic                spi_mode;
    logic                spi_4wire;
    logic                serial_en;
    logic                outputs_en;
    logic                mon_en;
    logic                alarm_en;
    logic                seq_done;
    logic [3:0]          cfg_num;
    logic                otp_ok;
    logic                otp_err;
    logic                ee_absent;
    logic                ee_cfg_ok;
    logic                ee_cfg_none;
  } seq_t;

  seq_t              st;
  seq_t              next_st;
  logic [GPIO_W+1:0] sync_bus;
  logic              pin_s;
  logic              test_s;
  logic [GPIO_W-1:0] gpio_s;
  logic              rise;
  logic              go;
  logic              skip;

  // zero-extended configuration selection from latched pins
  function automatic logic [3:0] sel_of(input logic [GPIO_W-1:0] g);
    logic [3:0] s;
    s = '0;
    s[SEL_PINS-1:0] = g[`RCS_SEL_LSB +: SEL_PINS];
    return s;
  endfunction : sel_of

  // job that a stage hands to the loader engine
  function automatic rcs_pkg::task_t task_of(input rcs_pkg::seq_state_t s);
    unique case (s)
      rcs_pkg::S_DEFAULTS: return rcs_pkg::T_DEFAULTS;
      rcs_pkg::S_PROBE:    return rcs_pkg::T_PROBE;
      rcs_pkg::S_UPDATE:   return rcs_pkg::T_UPDATE;
      rcs_pkg::S_OTP:      return rcs_pkg::T_OTP_CFG;
      rcs_pkg::S_EECFG:    return rcs_pkg::T_EE_CFG;
      rcs_pkg::S_HOTFIX:   return rcs_pkg::T_HOTFIX;
      rcs_pkg::S_APPLY:    return rcs_pkg::T_APPLY;
      default:             return rcs_pkg::T_INFO;
    endcase
  endfunction : task_of

  // -----------------------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------------------
  pin_sync #(
    .W (GPIO_W + 2)
  ) u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_pin     ({i_test_mode_n, i_master_reset_n, i_gpio}),
    .o_sync    (sync_bus)
  );

  assign test_s = sync_bus[GPIO_W+1];
  assign pin_s  = sync_bus[GPIO_W];
  assign gpio_s = sync_bus[GPIO_W-1:0];
  assign rise   = pin_s & ~st.pin_prev;

  // -----------------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------------
  always_comb begin
    next_st           = st;
    next_st.pll_start = 1'b0;
    next_st.pin_prev  = pin_s;
    go                = 1'b0;
    // stages whose job is not needed fall straight through
    skip = (st.state == rcs_pkg::S_PROBE &&
            (!st.gpio_lat[`RCS_GPIO_EE_EN] || st.spi_mode)) ||
           (st.state == rcs_pkg::S_UPDATE && (!st.ee_found || st.upd_done)) ||
           (st.state == rcs_pkg::S_EECFG && (!st.ee_found || st.spi_mode)) ||
           (st.state == rcs_pkg::S_HOTFIX && !i_hotfix_present);

    // one job at a time: issue, then wait for its done pulse
    if (task_of(st.state) != rcs_pkg::T_INFO || st.state == rcs_pkg::S_INFO) begin
      if (!skip && !st.busy) begin
        next_st.busy = 1'b1;
        next_st.tsk  = task_of(st.state);
      end else if (st.busy && i_task_done) begin
        next_st.busy = 1'b0;
        go           = 1'b1;
      end
    end

    unique case (st.state)
      rcs_pkg::S_INFO: begin
        if (go) next_st.state = rcs_pkg::S_PLL0;
      end
      rcs_pkg::S_PLL0: begin
        // lock may be stale while the start pulse stands, so it is judged after it
        if (!st.busy) begin
          next_st.busy      = 1'b1;
          next_st.pll_start = 1'b1;
        end else if (!st.pll_start && i_pll_lock) begin
          next_st.busy  = 1'b0;
          next_st.state = rcs_pkg::S_HOLD;
        end
      end
      rcs_pkg::S_HOLD: begin
        if (st.released) next_st.state = rcs_pkg::S_DEFAULTS;
      end
      rcs_pkg::S_DEFAULTS: begin
        if (go) begin
          next_st.spi_mode  = st.gpio_lat[`RCS_GPIO_SPI];
          next_st.spi_4wire = 1'b1;
          next_st.ee_idx    = '0;
          next_st.ee_spd    = rcs_pkg::EE_1MHZ;
          next_st.state     = rcs_pkg::S_PROBE;
        end
      end
      rcs_pkg::S_PROBE: begin
        if (skip) begin
          next_st.state = rcs_pkg::S_UPDATE;
        end else if (go && i_task_ok) begin
          next_st.ee_found = 1'b1;
          next_st.state    = rcs_pkg::S_UPDATE;
        end else if (go) begin
          // sweep all eight addresses, then drop to the next slower speed
          next_st.ee_idx = st.ee_idx + 3'h1;
          if (st.ee_idx == `RCS_EE_LAST_IDX) begin
            unique case (st.ee_spd)
              rcs_pkg::EE_1MHZ:   next_st.ee_spd = rcs_pkg::EE_400KHZ;
              rcs_pkg::EE_400KHZ: next_st.ee_spd = rcs_pkg::EE_100KHZ;
              default: begin
                next_st.ee_absent = 1'b1;
                next_st.state     = rcs_pkg::S_UPDATE;
              end
            endcase
          end
        end
      end
      rcs_pkg::S_UPDATE: begin
        if (go && i_task_ok) begin
          // update applied: back to the initial reset state, once per pin reset
          next_st.upd_done = 1'b1;
          next_st.state    = rcs_pkg::S_INFO;
        end else if (skip || go) begin
          next_st.state = rcs_pkg::S_OTP;
        end
      end
      rcs_pkg::S_OTP: begin
        if (go && i_task_ok) begin
          next_st.cfg_loaded = 1'b1;
          next_st.otp_ok     = 1'b1;
          next_st.cfg_num    = sel_of(st.gpio_lat);
          next_st.pll_start  = i_cfg_fbdiv;
          next_st.spi_mode   = i_cfg_spi_mode;
          next_st.spi_4wire  = !i_cfg_spi_3wire;
        end else if (go) begin
          next_st.otp_err = 1'b1;
        end
        next_st.ee_off = 1'b0;
        if (go) next_st.state = rcs_pkg::S_EECFG;
      end
      rcs_pkg::S_EECFG: begin
        if (go && i_task_ok) begin
          next_st.cfg_loaded = 1'b1;
          next_st.ee_cfg_ok  = 1'b1;
          next_st.state      = rcs_pkg::S_HOTFIX;
        end else if (skip || (go && st.ee_off)) begin
          next_st.ee_cfg_none = st.ee_found && !skip;
          next_st.state       = rcs_pkg::S_HOTFIX;
        end else if (go) begin
          next_st.ee_off = 1'b1;
        end
      end
      rcs_pkg::S_HOTFIX: begin
        if (skip || go) next_st.state = rcs_pkg::S_RECAL;
      end
      rcs_pkg::S_RECAL: begin
        if (!st.cfg_loaded) begin
          next_st.state = rcs_pkg::S_SERIAL;
        end else if (!st.busy) begin
          next_st.busy      = 1'b1;
          next_st.pll_start = 1'b1;
        end else if (!st.pll_start && i_pll_lock) begin
          next_st.busy  = 1'b0;
          next_st.state = rcs_pkg::S_SERIAL;
        end
      end
      rcs_pkg::S_SERIAL: begin
        next_st.serial_en = 1'b1;
        next_st.state     = rcs_pkg::S_APPLY;
      end
      rcs_pkg::S_APPLY: begin
        if (go) next_st.state = rcs_pkg::S_OUTPUTS;
      end
      rcs_pkg::S_OUTPUTS: begin
        next_st.outputs_en = 1'b1;
        next_st.state      = rcs_pkg::S_MONITORS;
      end
      rcs_pkg::S_MONITORS: begin
        next_st.mon_en = 1'b1;
        next_st.state  = rcs_pkg::S_ALARMS;
      end
      rcs_pkg::S_ALARMS: begin
        next_st.alarm_en = 1'b1;
        next_st.seq_done = 1'b1;
        next_st.state    = rcs_pkg::S_RUN;
      end
      rcs_pkg::S_RUN: begin
        next_st.state = rcs_pkg::S_RUN;
      end
    endcase

    // master reset pin: a long enough low restarts everything, overriding the above
    if (!pin_s) begin
      if (st.low_cnt != 2'h3) next_st.low_cnt = st.low_cnt + 2'h1;
      if (32'(st.low_cnt) + 32'd1 >= `RCS_MIN_LOW_CYC) begin
        // once in reset, info load and calibration keep stepping while the pin stays low
        if (!st.in_reset) begin
          next_st            = '0;
          next_st.low_cnt    = st.low_cnt;
          next_st.in_reset   = 1'b1;
          next_st.state      = rcs_pkg::S_INFO;
          next_st.tsk        = rcs_pkg::T_INFO;
          next_st.ee_spd     = rcs_pkg::EE_1MHZ;
          next_st.spi_4wire  = 1'b1;
          if (st.low_cnt != 2'h3) next_st.low_cnt = st.low_cnt + 2'h1;
        end
      end
    end else begin
      next_st.low_cnt = '0;
      // release only counts with the test input high
      if (rise && st.in_reset && test_s) begin
        next_st.in_reset = 1'b0;
        next_st.released = 1'b1;
        next_st.gpio_lat = gpio_s;
      end
    end
  end

  // -----------------------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st           <= '0;
      st.in_reset  <= 1'b1;
      st.spi_4wire <= 1'b1;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  // -----------------------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------------------
  assign o_task_req      = st.busy && st.state != rcs_pkg::S_PLL0 && st.state != rcs_pkg::S_RECAL;
  assign o_task          = st.tsk;
  assign o_ee_addr       = {`RCS_EE_BASE_HI, st.ee_idx};
  assign o_ee_speed      = st.ee_spd;
  assign o_ee_offset     = st.ee_off ? `RCS_EE_OFF_HIGH : `RCS_EE_OFF_LOW;
  assign o_cfg_sel       = sel_of(st.gpio_lat);
  assign o_pll_cal_start = st.pll_start;
  assign o_spi_mode      = st.spi_mode;
  assign o_spi_4wire     = st.spi_4wire;
  assign o_serial_en     = st.serial_en;
  assign o_clk_out_en    = st.outputs_en;
  assign o_gpio_out_en   = st.outputs_en;
  assign o_mon_en        = st.mon_en;
  assign o_alarm_en      = st.alarm_en;
  assign o_seq_done      = st.seq_done;
  assign o_cfg_num       = st.cfg_num;
  // load and failure summary, defaults-only in the top bit
  assign o_status = {st.seq_done && !st.cfg_loaded, st.ee_cfg_none, st.ee_absent,
                     st.otp_err, st.upd_done, st.otp_ok, st.ee_cfg_ok};

  // -----------------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------------
  chk_reset_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st.in_reset |-> !o_serial_en && !o_clk_out_en && !o_gpio_out_en)
    else $error("outputs active during reset");

  chk_low_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && !pin_s) [*2] |=> st.in_reset)
    else $error("two low samples did not reset");

  chk_latch_edge: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && rise && st.in_reset && test_s |=> st.gpio_lat == $past(gpio_s) && st.released)
    else $error("pins not latched at release");

  chk_test_block: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && rise && st.in_reset && !test_s |=> st.in_reset)
    else $error("sequence left reset in test mode");

  chk_spi_no_ee: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_task_req && (o_task == rcs_pkg::T_PROBE || o_task == rcs_pkg::T_EE_CFG) |-> !st.spi_mode)
    else $error("memory access in peripheral mode");

  chk_probe_addr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_task_req && o_task == rcs_pkg::T_PROBE |-> o_ee_addr[6:3] == 4'hA)
    else $error("probe address out of range");

  chk_cfg_offset: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_task_req && o_task == rcs_pkg::T_EE_CFG |-> o_ee_offset inside {16'h0000, 16'hF000})
    else $error("bad configuration offset");

  chk_fbdiv_cal: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && st.state == rcs_pkg::S_OTP && st.busy && i_task_done && i_task_ok && i_cfg_fbdiv
    && pin_s |=> o_pll_cal_start)
    else $error("calibration not started after divider load");

  chk_done_order: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(o_seq_done) |-> o_alarm_en && $past(o_mon_en) && o_serial_en && o_clk_out_en)
    else $error("completion steps out of order");

  chk_update_restart: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && st.state == rcs_pkg::S_UPDATE && st.busy && i_task_done && i_task_ok && pin_s
    |=> st.state == rcs_pkg::S_INFO && st.upd_done)
    else $error("update did not restart sequence");

endmodule : reset_config_sequencer

// >>> reset_config_sequencer_regs.svh
/*
  Constants of the reset and start-up configuration sequencer: latched pin field
  positions, the two-wire memory probe range and offsets, and reset timing counts.
  Assumes a 100 MHz system clock and inclusion by bare name.
*/
// Function
// - a low master reset pulse of 20ns fully resets a powered device
// - sequence starts at master reset rising edge only with test mode input high
// - in reset: clock outputs off, pins inputs, serial port silent
// - before release: load factory info block, then calibrate and lock system PLL
// - latch pin levels at reset rising edge; driver holds them about 10ns
// - after release build register image at defaults, pins and outputs unchanged
// - serial protocol from latched pin; peripheral mode defaults to four-wire
// - valid memory update found: load, apply, restart from initial reset state
// - latched pins pick OTP configuration; missing or bad flags error, good reports number
// - OTP configuration overwrites only listed registers; others keep defaults
// - configuration programming PLL feedback divider starts calibration at once; code does this only for OTP configuration (i_cfg_fbdiv)
// - after OTP load, serial port switches to protocol the loaded registers select
// - memory search skips bad blocks until range covered or one block applied
// - OTP hotfix loads into RAM and runs after searches, before completion
// - completion order: PLL relock, serial, apply image, outputs, monitors, alarms
// - status bits show failures, including finishing with defaults only
// - probe addresses 1010000..1010111 at 1MHz, then 400kHz, then 100kHz
// - skip every memory search while serial port is in peripheral mode
// - configuration search checks offsets 0x0000 and 0xF000
// - fewer than four selection pins fill low bits, upper bits zero
`ifndef RESET_CONFIG_SEQUENCER_REGS_SVH
`define RESET_CONFIG_SEQUENCER_REGS_SVH

// -----------------------------------------------------------------------------
// latched pin fields
// -----------------------------------------------------------------------------
`define RCS_SEL_LSB        0
`define RCS_SEL_W          4
`define RCS_GPIO_EE_EN     4
`define RCS_GPIO_SPI       5

// -----------------------------------------------------------------------------
// two-wire memory probe
// -----------------------------------------------------------------------------
`define RCS_EE_BASE_HI     4'hA
`define RCS_EE_LAST_IDX    3'h7
`define RCS_EE_OFF_LOW     16'h0000
`define RCS_EE_OFF_HIGH    16'hF000

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define RCS_CLK_NS         10
`define RCS_MIN_LOW_NS     20
`define RCS_MIN_LOW_CYC    ((`RCS_MIN_LOW_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS)
`define RCS_PIN_HOLD_NS    10

`endif

// >>> rcs_pkg.sv
/*
  Types of the reset and start-up configuration sequencer.
  Assumes nothing of its surroundings.
*/
package rcs_pkg;

  // sequencer stages
  typedef enum logic [4:0] {
    S_INFO, S_PLL0, S_HOLD, S_DEFAULTS, S_PROBE, S_UPDATE, S_OTP, S_EECFG,
    S_HOTFIX, S_RECAL, S_SERIAL, S_APPLY, S_OUTPUTS, S_MONITORS, S_ALARMS, S_RUN
  } seq_state_t;

  // jobs handed to the loader engine
  typedef enum logic [2:0] {
    T_INFO, T_DEFAULTS, T_PROBE, T_UPDATE, T_OTP_CFG, T_EE_CFG, T_HOTFIX, T_APPLY
  } task_t;

  // two-wire master speed during the probe sweep
  typedef enum logic [1:0] {
    EE_1MHZ, EE_400KHZ, EE_100KHZ
  } ee_speed_t;

endpackage : rcs_pkg

// >>> pin_sync.sv
/*
  Two flip-flop synchroniser for a group of pin levels.
  Assumes pins are asynchronous to i_sys_clk; resets every stage to zero.
*/
`timescale 1ns/100ps

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta;

  // -----------------------------------------------------------------------------
  // first stage feeds only the second
  // -----------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else if (i_ce) begin
      meta   <= i_pin;
      o_sync <= meta;
    end
  end

endmodule : pin_sync

// >>> loader_engine_model.sv
/* Loader engine and PLL stand-in for the start-up sequencer.
   Assumes knob bits from the bench: {delay, otp ok, hit, speed, idx, cfg place}. */
`timescale 1ns/100ps
module loader_engine_model (
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_task_req,
  input  wire rcs_pkg::task_t     i_task,
  input  wire logic [6:0]         i_ee_addr,
  input  wire rcs_pkg::ee_speed_t i_ee_speed,
  input  wire logic [15:0]        i_ee_offset,
  input  wire logic               i_pll_cal_start,
  input  wire logic [11:0]        i_knob,
  output logic                    o_task_done,
  output logic                    o_task_ok,
  output logic                    o_pll_lock
);
  logic [2:0] cnt;
  logic [2:0] lock_cnt;
  logic       ok;
  logic       fire;

  // job outcome; an update lands only with cfg place 3, the sequencer skips it on replay
  always_comb begin
    fire = i_task_req && !o_task_done && cnt >= i_knob[11:9];
    case (i_task)
      rcs_pkg::T_PROBE:   ok = i_knob[7] && i_ee_speed == i_knob[6:5] &&
                               i_ee_addr[2:0] == i_knob[4:2];
      rcs_pkg::T_UPDATE:  ok = i_knob[1:0] == 2'h3;
      rcs_pkg::T_OTP_CFG: ok = i_knob[8];
      rcs_pkg::T_EE_CFG:  ok = i_knob[1:0] != 2'h0 &&
                               i_ee_offset == (i_knob[1] ? 16'hF000 : 16'h0000);
      default:            ok = 1'b1;
    endcase
  end

  // answer after the delay; idle ok line toggles so a stale value never reads as valid
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 3'h0;
      lock_cnt <= 3'h0;
      o_task_done <= 1'b0;
      o_task_ok <= 1'b0;
      o_pll_lock <= 1'b0;
    end else begin
      o_task_done <= fire;
      o_task_ok <= fire ? ok : ~o_task_ok;
      cnt <= (i_task_req && !o_task_done) ? cnt + 3'h1 : 3'h0;
      lock_cnt <= i_pll_cal_start ? i_knob[11:9] : lock_cnt - 3'(lock_cnt != 3'h0);
      o_pll_lock <= !i_pll_cal_start && lock_cnt == 3'h0;
    end
  end
endmodule : loader_engine_model

// >>> reset_config_sequencer_test.sv
/* Bench of the start-up sequencer: job order and completion state against queued notes.
   Assumes the loader engine model answers every job and calibration. */
`timescale 1ns/100ps
module reset_config_sequencer_test;
  int          mismatches = 0, total_checks = 0, cycles = 0, seed = 32'h626f8fce;
  logic        clk = 1'b0, rst_n = 1'b0, mr_n = 1'b0, test_n = 1'b1, hot = 1'b0, mute = 1'b0;
  logic        req, done, ok, lock, cal, spi, spi4, ser, ck_en, io_en, mon, alm, sdone;
  logic        req_q = 1'b0, done_q = 1'b0;
  logic [2:0]  cfg = 3'h0;
  logic [3:0]  sel, num;
  logic [6:0]  addr, status;
  logic [7:0]  gpio = 8'h00;
  logic [11:0] knob = 12'h200;
  logic [15:0] off;
  logic [15:0] notes[$];
  rcs_pkg::task_t     job;
  rcs_pkg::ee_speed_t speed;

  initial begin
    forever #5 clk = ~clk;
  end

  reset_config_sequencer #(.GPIO_W(8), .SEL_PINS(2)) i_reset_config_sequencer (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_master_reset_n(mr_n),
    .i_test_mode_n(test_n), .i_gpio(gpio), .o_task_req(req), .o_task(job),
    .i_task_done(done), .i_task_ok(ok), .o_ee_addr(addr), .o_ee_speed(speed),
    .o_ee_offset(off), .o_cfg_sel(sel), .i_cfg_fbdiv(cfg[2]), .i_cfg_spi_mode(cfg[1]),
    .i_cfg_spi_3wire(cfg[0]), .i_hotfix_present(hot), .o_pll_cal_start(cal),
    .i_pll_lock(lock), .o_spi_mode(spi), .o_spi_4wire(spi4), .o_serial_en(ser),
    .o_clk_out_en(ck_en), .o_gpio_out_en(io_en), .o_mon_en(mon), .o_alarm_en(alm),
    .o_seq_done(sdone), .o_cfg_num(num), .o_status(status));
  loader_engine_model i_loader_engine_model (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_task_req(req), .i_task(job), .i_ee_addr(addr),
    .i_ee_speed(speed), .i_ee_offset(off), .i_pll_cal_start(cal), .i_knob(knob),
    .o_task_done(done), .o_task_ok(ok), .o_pll_lock(lock));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  function automatic logic [15:0] next_note();
    return notes.size() > 0 ? notes.pop_front() : 16'hFFFF;
  endfunction : next_note

  task automatic want(input rcs_pkg::task_t t);
    notes.push_back({13'h0, t});
  endtask : want

  // watcher samples mid-cycle, where registered outputs have settled
  always @(negedge clk) begin
    cycles++;
    if (!mute && rst_n && sdone && !done_q)
      check({2'h1, status, num, spi, spi4, ser & ck_en & io_en & mon & alm}, next_note());
    if (!mute && rst_n && req && !req_q)
      check({13'h0, job}, next_note());
    req_q = req;
    done_q = sdone;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // power-on reset with the pin low, then room for the info job and lock
  task automatic restart;
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    mr_n = 1'b0;
    mute = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (40) @(posedge clk);
    #1;
    check({12'h0, ser, ck_en, io_en, alm}, 16'h0);
  endtask : restart

  task automatic run(input logic ee, sp, otp, hit, input logic [1:0] spd,
                     input logic [2:0] idx, input logic [1:0] at, input logic h,
                     input logic [2:0] c);
    logic srch, pres, fnd, upd;
    srch = ee & ~sp;
    pres = srch & hit;
    fnd = pres & (at != 2'h0);
    upd = pres & (at == 2'h3);
    gpio = {2'($random(seed)), sp, ee, 4'($random(seed))};
    knob = {3'(1 + {$random(seed)} % 7), otp, hit, spd, idx, at};
    hot = h;
    cfg = c;
    // an applied update replays the start of the sequence once
    for (int p = 0; p <= int'(upd); p++) begin
      want(rcs_pkg::T_INFO);
      want(rcs_pkg::T_DEFAULTS);
      for (int i = 0; i < (hit ? spd * 8 + idx + 1 : 24); i++)
        if (srch) want(rcs_pkg::T_PROBE);
      if (pres && p == 0) want(rcs_pkg::T_UPDATE);
    end
    want(rcs_pkg::T_OTP_CFG);
    for (int i = 0; i < (at == 2'h1 ? 1 : 2); i++)
      if (pres) want(rcs_pkg::T_EE_CFG);
    if (h) want(rcs_pkg::T_HOTFIX);
    want(rcs_pkg::T_APPLY);
    notes.push_back({2'h1, ~otp & ~fnd, pres & ~fnd, srch & ~hit, ~otp, upd, otp, fnd,
                     otp ? {2'h0, gpio[1:0]} : 4'h0, otp ? c[1] : sp, ~otp | ~c[0], 1'b1});
    restart();
    mr_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    gpio = ~gpio;
    for (int i = 0; i < 2000 && sdone !== 1'b1; i++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    #1;
    check(16'(notes.size()), 16'h0);
    check({12'h0, sel}, {14'h0, ~gpio[1:0]});
  endtask : run

  initial begin
    run(1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 3'h0, 2'h0, 1'b1, 3'h4);
    run(1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 3'h0, 2'h1, 1'b0, 3'h0);
    run(1'b1, 1'b0, 1'b1, 1'b1, 2'h2, 3'h7, 2'h2, 1'b0, 3'h4);
    run(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 3'h0, 2'h0, 1'b1, 3'h0);
    run(1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 3'h0, 2'h1, 1'b0, 3'h3);
    run(1'b1, 1'b0, 1'b1, 1'b1, 2'h1, 3'h3, 2'h0, 1'b1, 3'h0);
    run(1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 3'h2, 2'h3, 1'b0, 3'h0);
    mute = 1'b1;
    mr_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    mr_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check({14'h0, alm, sdone}, 16'h0);
    test_n = 1'b0;
    want(rcs_pkg::T_INFO);
    restart();
    mr_n = 1'b1;
    repeat (60) @(posedge clk);
    #1;
    check({14'h0, req, ser}, 16'h0);
    check(16'(notes.size()), 16'h0);
    end_sim();
  end
endmodule : reset_config_sequencer_test
